// >>> bench/smb_bus_slave.sv
// Behavioural slave on the shared two-wire bus: acknowledges every byte.
// Assumes pull-ups outside; it only ever pulls lines low.
`timescale 1ns/1ps
// ==========
// Slave model
module smb_bus_slave (
   input wire logic scl,
   input wire logic sda,
   input wire logic stretch,
   output logic sclPull,
   output logic sdaPull
);
   int bitCnt;
   initial begin
      sclPull = 1'h0;
      sdaPull = 1'h0;
      bitCnt = 0;
   end
   always @(negedge sda) begin
      if (scl) begin
         bitCnt = 0;
      end
   end
   always @(posedge scl) begin
      if (!sdaPull) begin
         bitCnt++;
      end
   end
   always @(negedge scl) begin
      if (sdaPull) begin
         sdaPull = 1'h0;
      end else if (bitCnt == 8) begin
         sdaPull = 1'h1;
         bitCnt = 0;
      end
      // Long stretch so the master must wait on the released line
      if (stretch) begin
         sclPull = 1'h1;
         #300;
         sclPull = 1'h0;
      end
   end
endmodule : smb_bus_slave

// >>> bench/smb_ctrl_tb.sv
// Self-checking bench for the bus controller acting as master and as slave.
// Assumes one overflow pulse every ten clocks feeds the timer 0 and timer 2 low sources.
`timescale 1ns/1ps
// ==========
// Bench top
module smb_ctrl_tb;
   logic clk = 1'h0, rst_n = 1'h0, ovf = 1'h0, en = 1'h0, startReq = 1'h0, stopReq = 1'h0;
   logic rel = 1'h0, stretch = 1'h0, toEn = 1'h0, ftEn = 1'h0, sclGrab = 1'h0, sdaGrab = 1'h0;
   logic slvInh = 1'h0, arbLost, sclO, sdaO;
   logic [1:0] csel = 2'h0;
   logic [7:0] tx = 8'h00, rxByte;
   logic sclOe, sdaOe, sclPull, sdaPull, evt, sFlag, pFlag, ackRx, mMode, tMode, busy, reload;
   wire scl = !(sclOe | sclPull | sclGrab);
   wire sda = !(sdaOe | sdaPull | sdaGrab);
   int num_errors = 0, num_checks = 0, cnt = 0;
   always #12.5 clk = !clk;
   always @(posedge clk) begin
      #1;
      cnt = (cnt == 9) ? 0 : cnt + 1;
      ovf = (cnt == 0);
   end
   smb_bus_slave peer (.scl(scl), .sda(sda), .stretch(stretch), .sclPull(sclPull),
      .sdaPull(sdaPull));
   smb_ctrl uut (.clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sclOut(sclO),
      .sclOe(sclOe), .sdaOut(sdaO), .sdaOe(sdaOe), .timer0Ovf(ovf), .timer1Ovf(1'h0),
      .timer2HiOvf(1'h0), .timer2LoOvf(ovf), .interfaceEnable(en), .slaveInhibit(slvInh),
      .sclLowTimeoutEnable(toEn), .busFreeTimeoutEnable(ftEn), .clockSourceSelectHi(csel[1]),
      .clockSourceSelectLo(csel[0]), .ownAddress(7'h11), .startRequest(startReq),
      .stopRequest(stopReq), .eventRelease(rel), .ackOut(1'h1), .txByte(tx),
      .eventPending(evt), .startFlag(sFlag), .stopFlag(pFlag), .ackReceived(ackRx),
      .rxByte(rxByte), .masterMode(mMode), .transmitMode(tMode), .busBusy(busy),
      .arbitrationLost(arbLost), .timeoutReload(reload));
   // ==========
   // Shared tasks
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic wait_evt(input int lim);
      int i;
      for (i = 0; i < lim && evt !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(evt, 1'h1, "no event");
      if (evt !== 1'h1) begin
         give_verdict();
      end
   endtask : wait_evt
   task automatic release_evt(input logic [7:0] b, input logic stp);
      @(posedge clk);
      #1;
      rel = 1'h1;
      tx = b;
      stopReq = stp;
      @(posedge clk);
      #1;
      rel = 1'h0;
   endtask : release_evt
   // ==========
   // Scenarios
   task automatic test_disabled();
      int i;
      startReq = 1'h1;
      for (i = 0; i < 200; i++) begin
         @(posedge clk);
         #1;
         chk(sclOe | sdaOe, 1'h0, "drive while disabled");
      end
      startReq = 1'h0;
      $display("test_disabled done");
   endtask : test_disabled
   task automatic test_write();
      en = 1'h1;
      toEn = 1'h1;
      startReq = 1'h1;
      @(posedge clk);
      #1;
      startReq = 1'h0;
      wait_evt(400);
      chk(sFlag, 1'h1, "start flag");
      chk(mMode, 1'h1, "master");
      release_evt(8'hA4, 1'h0);
      wait_evt(800);
      chk(ackRx, 1'h1, "address ack");
      chk(reload, 1'h0, "timer counts while SCL low");
      chk(tMode, 1'h1, "write direction");
      stretch = 1'h1;
      release_evt(8'h5A, 1'h0);
      wait_evt(1500);
      stretch = 1'h0;
      chk(ackRx, 1'h1, "data ack");
      chk(rxByte, 8'h5A, "byte on wire");
      release_evt(8'h00, 1'h1);
      repeat (200) @(posedge clk);
      #1;
      chk(busy, 1'h0, "bus free after stop");
      chk({scl, sda}, 2'h3, "lines released");
      chk({sclO, sdaO}, 2'h0, "pads only pull low");
      $display("test_write done");
   endtask : test_write
   task automatic host_byte(input logic [7:0] b);
      int i;
      for (i = 7; i >= 0; i--) begin
         sclGrab = 1'h1;
         repeat (10) @(posedge clk);
         #1;
         sdaGrab = !b[i];
         repeat (10) @(posedge clk);
         #1;
         sclGrab = 1'h0;
         repeat (20) @(posedge clk);
         #1;
      end
      sclGrab = 1'h1;
      repeat (10) @(posedge clk);
      #1;
      sdaGrab = 1'h0;
   endtask : host_byte
   task automatic host_stop();
      sclGrab = 1'h0;
      repeat (20) @(posedge clk);
      #1;
      sclGrab = 1'h1;
      repeat (10) @(posedge clk);
      #1;
      sdaGrab = 1'h1;
      repeat (10) @(posedge clk);
      #1;
      sclGrab = 1'h0;
      repeat (20) @(posedge clk);
      #1;
      sdaGrab = 1'h0;
   endtask : host_stop
   task automatic test_slave(input logic slave_inhibit);
      slvInh = slave_inhibit;
      sdaGrab = 1'h1;
      repeat (20) @(posedge clk);
      #1;
      host_byte(8'h22);
      chk(evt, !slave_inhibit, "address event before ack");
      chk(sclOe, !slave_inhibit, "slave stretch while event waits");
      if (!slave_inhibit) begin
         chk(rxByte, 8'h22, "address byte");
         release_evt(8'h00, 1'h0);
      end
      chk(sdaOe, !slave_inhibit, "address ack");
      host_stop();
      repeat (10) @(posedge clk);
      #1;
      chk(pFlag, !slave_inhibit, "slave stop event");
      chk(busy, 1'h0, "free after slave stop");
      if (!slave_inhibit) begin
         release_evt(8'h00, 1'h0);
      end
      $display("test_slave done");
   endtask : test_slave
   task automatic test_arb();
      startReq = 1'h1;
      @(posedge clk);
      #1;
      startReq = 1'h0;
      wait_evt(400);
      sdaGrab = 1'h1;
      release_evt(8'hA4, 1'h0);
      repeat (60) @(posedge clk);
      #1;
      chk(arbLost, 1'h1, "arbitration lost");
      chk(mMode, 1'h0, "loser became slave");
      chk(sclOe | sdaOe, 1'h0, "loser released lines");
      sdaGrab = 1'h0;
      repeat (20) @(posedge clk);
      #1;
      chk(busy, 1'h0, "free after foreign stop");
      $display("test_arb done");
   endtask : test_arb
   task automatic test_free();
      csel = 2'h3;
      ftEn = 1'h1;
      wait_evt(300);
      chk(pFlag, 1'h1, "free timeout stop");
      release_evt(8'h00, 1'h0);
      ftEn = 1'h0;
      $display("test_free done");
   endtask : test_free
   task automatic test_reload();
      toEn = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      chk(reload, 1'h1, "reload while high");
      en = 1'h0;
      @(posedge clk);
      #1;
      chk({reload, evt, busy}, 3'h0, "disabled interface idle");
      en = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      chk({reload, mMode, busy}, 3'h4, "re-enabled interface idle");
      $display("test_reload done");
   endtask : test_reload
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      test_disabled();
      test_write();
      test_slave(1'h1);
      test_slave(1'h0);
      test_arb();
      test_free();
      test_reload();
      give_verdict();
   end
endmodule : smb_ctrl_tb

// >>> hdl/smb_clk_src.sv
// Selects the bit-timing overflow and detects a free bus.
// Assumes the overflow inputs are one-cycle pulses on clk.
`timescale 1ns/1ps
module smb_clk_src (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] sourceSelect,
   input wire logic timer0Ovf,
   input wire logic timer1Ovf,
   input wire logic timer2HiOvf,
   input wire logic timer2LoOvf,
   input wire logic freeEnable,
   smb_line_if.src line
);
   import smb_pkg::*;

   logic selOvf;
   logic tick_q;
   logic free_q;
   logic [3:0] freeCnt_q;

   always_comb begin
      case (sourceSelect)
         SRC_TIMER0: selOvf = timer0Ovf;
         SRC_TIMER1: selOvf = timer1Ovf;
         SRC_TIMER2_HI: selOvf = timer2HiOvf;
         SRC_TIMER2_LO: selOvf = timer2LoOvf;
         default: selOvf = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= selOvf;
      end
   end

   // Counts source periods even when only a slave
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freeCnt_q <= 4'h0;
         free_q <= 1'b0;
      end else if (!freeEnable || !(line.scl && line.sda)) begin
         freeCnt_q <= 4'h0;
         free_q <= 1'b0;
      end else begin
         free_q <= tick_q && (freeCnt_q == FREE_LIMIT);
         if (tick_q && (freeCnt_q != FREE_LIMIT + 4'h1)) begin
            freeCnt_q <= freeCnt_q + 4'h1;
         end
      end
   end

   assign line.tick = tick_q;
   assign line.freeTimeout = free_q;
endmodule : smb_clk_src

// >>> hdl/smb_ctrl.sv
// Byte-level two-wire bus controller, master and slave, multi-master.
// Assumes open-drain pads outside; software drives the plain control ports.
`timescale 1ns/1ps
module smb_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sclOut,
   output logic sclOe,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic timer0Ovf,
   input wire logic timer1Ovf,
   input wire logic timer2HiOvf,
   input wire logic timer2LoOvf,
   input wire logic interfaceEnable,
   input wire logic slaveInhibit,
   input wire logic sclLowTimeoutEnable,
   input wire logic busFreeTimeoutEnable,
   input wire logic clockSourceSelectHi,
   input wire logic clockSourceSelectLo,
   input wire logic [smb_pkg::ADDR_W-1:0] ownAddress,
   input wire logic startRequest,
   input wire logic stopRequest,
   input wire logic eventRelease,
   input wire logic ackOut,
   input wire logic [smb_pkg::BYTE_W-1:0] txByte,
   output logic eventPending,
   output logic startFlag,
   output logic stopFlag,
   output logic ackReceived,
   output logic [smb_pkg::BYTE_W-1:0] rxByte,
   output logic masterMode,
   output logic transmitMode,
   output logic busBusy,
   output logic arbitrationLost,
   output logic timeoutReload
);
   import smb_pkg::*;

   // ==========================================================
   // Line conditioning and timing source
   smb_line_if line ();

   smb_line_sync uSync (
      .clk(clk),
      .rst_n(rst_n),
      .sclIn(sclIn),
      .sdaIn(sdaIn),
      .line(line)
   );

   smb_clk_src uSrc (
      .clk(clk),
      .rst_n(rst_n),
      .sourceSelect({clockSourceSelectHi, clockSourceSelectLo}),
      .timer0Ovf(timer0Ovf),
      .timer1Ovf(timer1Ovf),
      .timer2HiOvf(timer2HiOvf),
      .timer2LoOvf(timer2LoOvf),
      .freeEnable(busFreeTimeoutEnable && interfaceEnable),
      .line(line)
   );

   // ==========================================================
   // State
   smb_state_type state_q;
   logic master_q;
   logic tx_q;
   logic [3:0] bitCnt_q;
   logic [BYTE_W-1:0] shift_q;
   logic [BYTE_W-1:0] rxByte_q;
   logic sdaDrv_q;
   logic sclDrv_q;
   logic [1:0] hiCnt_q;
   logic addrPhase_q;
   logic dirRead_q;
   logic holdAck_q;
   logic stopPend_q;
   logic inhibit_q;
   logic slaveAct_q;
   logic ackIn_q;
   logic arbLost_q;
   logic irq_q;
   logic startF_q;
   logic stopF_q;
   logic startPend_q;
   logic busy_q;
   logic reload_q;

   // ==========================================================
   // Event decode
   logic en;
   logic release_;
   logic byteFall;
   logic addrMatch;
   logic addrReject;
   logic evRxByte;
   logic evTxByte;
   logic evStartGen;
   logic evStopDet;
   logic relPhase;
   logic genPhase;
   logic hiDone;
   logic arbLoss;
   logic nextTx;

   always_comb begin
      en = interfaceEnable;
      release_ = eventRelease && irq_q;
      byteFall = (state_q == ST_DATA) && line.sclFall && (bitCnt_q == ACK_SLOT);
      addrMatch = shift_q[BYTE_W-1:1] == ownAddress;
      addrReject = byteFall && !tx_q && addrPhase_q && !master_q
                   && (!addrMatch || inhibit_q);
      evRxByte = byteFall && !tx_q && !addrReject;
      evTxByte = (state_q == ST_ACK) && line.sclFall && !holdAck_q;
      evStartGen = (state_q == ST_START) && sclDrv_q;
      evStopDet = (line.stopSeen && slaveAct_q) || line.freeTimeout;
      relPhase = (state_q == ST_DATA) || (state_q == ST_ACK) || (state_q == ST_STOP);
      genPhase = (state_q == ST_START) || (state_q == ST_DATA) || (state_q == ST_ACK);
      hiDone = line.scl && line.tick && (hiCnt_q == HIGH_TICKS - 2'h1);
      arbLoss = (state_q == ST_DATA) && master_q && tx_q && line.sclRise
                && !sdaDrv_q && !line.sda;
      nextTx = (addrPhase_q && !master_q) ? dirRead_q
               : ((addrPhase_q && master_q) ? !dirRead_q : tx_q);
   end

   // ==========================================================
   // Byte sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         master_q <= 1'b0;
         tx_q <= 1'b0;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         sdaDrv_q <= 1'b0;
         addrPhase_q <= 1'b0;
         dirRead_q <= 1'b0;
         holdAck_q <= 1'b0;
         stopPend_q <= 1'b0;
         inhibit_q <= 1'b0;
         slaveAct_q <= 1'b0;
         ackIn_q <= 1'b0;
      end else if (!en) begin
         state_q <= ST_IDLE;
         master_q <= 1'b0;
         tx_q <= 1'b0;
         sdaDrv_q <= 1'b0;
         slaveAct_q <= 1'b0;
         holdAck_q <= 1'b0;
      end else if (line.stopSeen || line.freeTimeout) begin
         state_q <= ST_IDLE;
         master_q <= 1'b0;
         tx_q <= 1'b0;
         sdaDrv_q <= 1'b0;
         slaveAct_q <= 1'b0;
         holdAck_q <= 1'b0;
      end else if (line.startSeen && !master_q) begin
         state_q <= ST_DATA;
         tx_q <= 1'b0;
         bitCnt_q <= 4'h0;
         addrPhase_q <= 1'b1;
         inhibit_q <= slaveInhibit;
         slaveAct_q <= 1'b0;
         sdaDrv_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startPend_q && !busy_q) begin
                  state_q <= ST_START;
                  master_q <= 1'b1;
                  tx_q <= 1'b1;
                  sdaDrv_q <= 1'b1;
                  addrPhase_q <= 1'b1;
               end
            end
            ST_START: begin
               if (sclDrv_q) begin
                  state_q <= ST_HOLD;
                  holdAck_q <= 1'b0;
               end
            end
            ST_HOLD: begin
               if (release_) begin
                  shift_q <= txByte;
                  stopPend_q <= stopRequest && master_q;
                  if (stopRequest && master_q && !holdAck_q) begin
                     state_q <= ST_STOP;
                     sdaDrv_q <= 1'b1;
                  end else if (holdAck_q) begin
                     state_q <= ST_ACK;
                     sdaDrv_q <= ackOut;
                  end else begin
                     state_q <= ST_DATA;
                     bitCnt_q <= 4'h0;
                     sdaDrv_q <= tx_q && !txByte[BYTE_W-1];
                  end
               end
            end
            ST_DATA: begin
               if (line.sclRise) begin
                  shift_q <= {shift_q[BYTE_W-2:0], line.sda};
                  bitCnt_q <= bitCnt_q + 4'h1;
                  if (arbLoss) begin
                     master_q <= 1'b0;
                     tx_q <= 1'b0;
                  end
               end else if (line.sclFall) begin
                  if (bitCnt_q == ACK_SLOT) begin
                     if (addrPhase_q) begin
                        dirRead_q <= shift_q[0];
                     end
                     if (tx_q) begin
                        state_q <= ST_ACK;
                        sdaDrv_q <= 1'b0;
                        holdAck_q <= 1'b0;
                     end else if (addrReject) begin
                        state_q <= ST_IDLE;
                        sdaDrv_q <= 1'b0;
                     end else begin
                        state_q <= ST_HOLD;
                        holdAck_q <= 1'b1;
                        slaveAct_q <= slaveAct_q || !master_q;
                     end
                  end else begin
                     sdaDrv_q <= tx_q && !shift_q[BYTE_W-1];
                  end
               end
            end
            ST_ACK: begin
               if (line.sclRise) begin
                  ackIn_q <= !line.sda;
               end else if (line.sclFall) begin
                  if (holdAck_q) begin
                     holdAck_q <= 1'b0;
                     addrPhase_q <= 1'b0;
                     tx_q <= nextTx;
                     if (stopPend_q && master_q) begin
                        state_q <= ST_STOP;
                        sdaDrv_q <= 1'b1;
                     end else begin
                        state_q <= ST_DATA;
                        bitCnt_q <= 4'h0;
                        sdaDrv_q <= nextTx && !shift_q[BYTE_W-1];
                     end
                  end else begin
                     state_q <= ST_HOLD;
                     addrPhase_q <= 1'b0;
                     tx_q <= nextTx;
                  end
               end
            end
            ST_STOP: begin
               if (!sclDrv_q && hiDone) begin
                  state_q <= ST_IDLE;
                  sdaDrv_q <= 1'b0;
                  master_q <= 1'b0;
                  tx_q <= 1'b0;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // SCL driver: low phase one tick, high phase two ticks once seen high
   // Slaves only pull SCL while an event waits for software
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclDrv_q <= 1'b0;
         hiCnt_q <= 2'h0;
      end else if (!en) begin
         sclDrv_q <= 1'b0;
         hiCnt_q <= 2'h0;
      end else if (!master_q) begin
         sclDrv_q <= (state_q == ST_HOLD) && !release_;
         hiCnt_q <= 2'h0;
      end else if (sclDrv_q) begin
         hiCnt_q <= 2'h0;
         if (line.tick && relPhase) begin
            sclDrv_q <= 1'b0;
         end
      end else if (line.scl && line.tick) begin
         if (hiDone) begin
            hiCnt_q <= 2'h0;
            sclDrv_q <= genPhase;
         end else begin
            hiCnt_q <= hiCnt_q + 2'h1;
         end
      end
   end

   // ==========================================================
   // Event flags: a new event wins over a release in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
         startF_q <= 1'b0;
         stopF_q <= 1'b0;
         arbLost_q <= 1'b0;
         startPend_q <= 1'b0;
      end else if (!en) begin
         irq_q <= 1'b0;
         startF_q <= 1'b0;
         stopF_q <= 1'b0;
         arbLost_q <= 1'b0;
         startPend_q <= 1'b0;
      end else begin
         if (release_) begin
            irq_q <= 1'b0;
            startF_q <= 1'b0;
            stopF_q <= 1'b0;
            arbLost_q <= 1'b0;
         end
         if (evStartGen) begin
            startPend_q <= 1'b0;
         end
         if (startRequest) begin
            startPend_q <= 1'b1;
         end
         if (evRxByte || evTxByte || evStartGen || evStopDet) begin
            irq_q <= 1'b1;
         end
         if (evStartGen) begin
            startF_q <= 1'b1;
         end
         if (evStopDet) begin
            stopF_q <= 1'b1;
         end
         if (arbLoss) begin
            arbLost_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Bus status, received byte and timeout timer control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         reload_q <= 1'b0;
         rxByte_q <= 8'h00;
      end else begin
         if (!en || line.stopSeen || line.freeTimeout) begin
            busy_q <= 1'b0;
         end else if (line.startSeen) begin
            busy_q <= 1'b1;
         end
         reload_q <= en && sclLowTimeoutEnable && line.scl;
         if (byteFall) begin
            rxByte_q <= shift_q;
         end
      end
   end

   // Open-drain pads only ever pull low; bit time follows the selected overflow period
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = sclDrv_q;
   assign sdaOe = sdaDrv_q;
   assign eventPending = irq_q;
   assign startFlag = startF_q;
   assign stopFlag = stopF_q;
   assign ackReceived = ackIn_q;
   assign rxByte = rxByte_q;
   assign masterMode = master_q;
   assign transmitMode = tx_q;
   assign busBusy = busy_q;
   assign arbitrationLost = arbLost_q;
   assign timeoutReload = reload_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_START_IRQ: assert property (evStartGen |=> irq_q && startF_q && state_q == ST_HOLD)
      else $error("START generation did not raise the event");
   AST_FREE_BUS_ONLY: assert property (state_q == ST_IDLE && busy_q |=> state_q != ST_START)
      else $error("Master start on a busy bus");
   AST_ARB_LOSS: assert property (arbLoss && en |=> !master_q ##1 !sclDrv_q)
      else $error("Lost arbitration but kept mastering");
   AST_INHIBIT_NACK: assert property (addrReject && en |=> state_q == ST_IDLE && !sdaDrv_q)
      else $error("Rejected address was acknowledged");
   AST_DISABLED_QUIET: assert property (!en |=> !sclDrv_q && !sdaDrv_q && !irq_q)
      else $error("Disabled interface touches the bus");
   AST_TIMER_RELOAD: assert property (en && sclLowTimeoutEnable && line.scl |=> timeoutReload)
      else $error("Timeout timer not reloaded while SCL high");
   AST_HIGH_SEEN: assert property (master_q && $rose(sclDrv_q) && state_q != ST_HOLD |-> $past(line.scl, 1))
      else $error("SCL driven low without high phase seen");
   AST_RX_BEFORE_ACK: assert property (evRxByte && en |=> irq_q && state_q == ST_HOLD && holdAck_q)
      else $error("Receive event not raised before acknowledge");
   AST_FREE_AS_STOP: assert property (line.freeTimeout && en |=> stopF_q && irq_q && !busy_q)
      else $error("Free timeout did not act as STOP");
   AST_SLAVE_STRETCH: assert property (!master_q && state_q == ST_HOLD && irq_q && !eventRelease && en |=> sclDrv_q)
      else $error("Slave released SCL with event pending");

   COV_MASTER_START: cover property (evStartGen);
   COV_SLAVE_ADDR: cover property (evRxByte && !master_q);
   COV_ARB_LOSS: cover property (arbLoss);
   COV_FREE: cover property (line.freeTimeout && en);
endmodule : smb_ctrl

// >>> hdl/smb_line_if.sv
// Carries synchronised bus lines, edges and timing strobes between modules.
// Assumes all members are driven on the system clock.
`timescale 1ns/1ps
interface smb_line_if;
   logic scl;
   logic sda;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic tick;
   logic freeTimeout;
   modport sync (output scl, sda, sclRise, sclFall, startSeen, stopSeen);
   modport src (input scl, sda, output tick, freeTimeout);
   modport core (input scl, sda, sclRise, sclFall, startSeen, stopSeen, tick, freeTimeout);
endinterface : smb_line_if

// >>> hdl/smb_line_sync.sv
// Synchronises SCL and SDA pins and finds edges, START and STOP.
// Assumes pins are asynchronous to clk; idle lines are high.
`timescale 1ns/1ps
module smb_line_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   smb_line_if.sync line
);
   import smb_pkg::*;

   logic [2:0] sclSh_q;
   logic [2:0] sdaSh_q;

   // Stage 0 feeds only stage 1; stage 2 is history for edge finding
   // Two clocks of latency still follow a bit every ten clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclSh_q <= 3'h7;
         sdaSh_q <= 3'h7;
      end else begin
         sclSh_q <= {sclSh_q[1:0], sclIn};
         sdaSh_q <= {sdaSh_q[1:0], sdaIn};
      end
   end

   // Detection works in both roles
   assign line.scl = sclSh_q[1];
   assign line.sda = sdaSh_q[1];
   assign line.sclRise = sclSh_q[1] & ~sclSh_q[2];
   assign line.sclFall = ~sclSh_q[1] & sclSh_q[2];
   assign line.startSeen = sclSh_q[1] & sclSh_q[2] & ~sdaSh_q[1] & sdaSh_q[2];
   assign line.stopSeen = sclSh_q[1] & sclSh_q[2] & sdaSh_q[1] & ~sdaSh_q[2];
endmodule : smb_line_sync

// >>> hdl/smb_pkg.sv
// Shared constants and state type for the two-wire bus controller.
// Assumes one 40 MHz system clock; timer overflows arrive as one-cycle pulses.
//
// Notes on behaviour
// - START, address byte, data bytes, then STOP.
// - Address LSB: one reads, zero writes.
// - Receiver pulls SDA low to acknowledge.
// - Transmitter waits for acknowledge after each byte.
// - Master starts only on a free bus.
// - Master seeing low on high loses, becomes slave.
// - Slaves may stretch SCL low; master waits.
// - Timeout timer reloads on SCL high, counts low.
// - Lines high over ten periods means bus free.
// - Free detection needs running clock source, even slave.
// - Byte interrupt: before ack sending, after ack receiving.
// - Interrupt on own START and slave-seen STOP.
// - Enable clear means no bus activity at all.
// - Inhibit: monitor, refuse addresses, no slave interrupts.
// - Inhibit takes effect only after next START.
// - Two select bits choose one of four overflows.
// - Clock source used by master or free detection.
// - Master SCL low and high at least one period.
// - Typical bit three periods, high twice low.
// - SCL pulses only as master; START/STOP both roles.
// - Free timeout acts like a detected STOP.
// - Bit rate up to one tenth system clock.
package smb_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SCL_LOW_TIMEOUT_MS = 25;
   localparam int unsigned SW_RECOVER_MS = 10;
   localparam int unsigned FREE_PERIODS = 10;
   localparam int unsigned MIN_CLKS_PER_BIT = 10;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 7;
   // Low phase lasts one tick, high phase this many ticks once SCL is seen high
   localparam logic [1:0] HIGH_TICKS = 2'h2;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] FREE_LIMIT = 4'hA;
   localparam logic [1:0] SRC_TIMER0 = 2'h0;
   localparam logic [1:0] SRC_TIMER1 = 2'h1;
   localparam logic [1:0] SRC_TIMER2_HI = 2'h2;
   localparam logic [1:0] SRC_TIMER2_LO = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_DATA = 3'h3,
      ST_ACK = 3'h2,
      ST_HOLD = 3'h6,
      ST_STOP = 3'h7
   } smb_state_type;
endpackage : smb_pkg
